// *** hw/avir_pkg.sv ***
package avir_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int AXI_ADDR_W = 12;
    localparam int AXI_DATA_W = 32;
    localparam int WORD_IDX_W = AXI_ADDR_W - 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Register indices, byte address is four times the index
    // ************************************************************
    localparam logic [WORD_IDX_W-1:0] IDX_VERSION = 10'h080;
    localparam logic [WORD_IDX_W-1:0] IDX_FORMAT = 10'h081;
    localparam logic [WORD_IDX_W-1:0] IDX_COLOUR = 10'h082;
    localparam logic [WORD_IDX_W-1:0] IDX_UNEVEN = 10'h083;
    localparam logic [WORD_IDX_W-1:0] IDX_VFI = 10'h084;
    localparam logic [WORD_IDX_W-1:0] IDX_FLAGS_A = 10'h087;
    localparam logic [WORD_IDX_W-1:0] IDX_FLAGS_B = 10'h08f;

    // ************************************************************
    // Field codes
    // ************************************************************
    localparam logic [1:0] CSPACE_RGB = 2'h0;
    localparam logic [1:0] CSPACE_YCC422 = 2'h1;
    localparam logic [1:0] CSPACE_YCC444 = 2'h2;
    localparam logic [1:0] BAR_NONE = 2'h0;
    localparam logic [1:0] BAR_HORIZ = 2'h1;
    localparam logic [1:0] BAR_VERT = 2'h2;
    localparam logic [1:0] BAR_BOTH = 2'h3;
    localparam logic [1:0] SCAN_NONE = 2'h0;
    localparam logic [1:0] SCAN_OVER = 2'h1;
    localparam logic [1:0] SCAN_UNDER = 2'h2;
    localparam logic [1:0] COLORI_NONE = 2'h0;
    localparam logic [1:0] COLORI_SD = 2'h1;
    localparam logic [1:0] COLORI_HD = 2'h2;
    localparam logic [3:0] AFAR_SAME = 4'h8;
    localparam logic [3:0] AFAR_4_3 = 4'h9;
    localparam logic [3:0] AFAR_16_9 = 4'ha;
    localparam logic [3:0] AFAR_14_9 = 4'hb;
    localparam logic [1:0] RESIZE_NONE = 2'h0;
    localparam logic [1:0] RESIZE_HORIZ = 2'h1;
    localparam logic [1:0] RESIZE_VERT = 2'h2;
    localparam logic [1:0] RESIZE_BOTH = 2'h3;

    localparam int FLAG_W = 7;
    localparam int FLAG_AVI = 0;

    // ************************************************************
    // Byte layouts and captured frame
    // ************************************************************
    typedef struct packed {
        logic spare;
        logic [1:0] colour_space;
        logic format_present;
        logic [1:0] bar_valid;
        logic [1:0] scan_info;
    } avir_format_t;

    typedef struct packed {
        logic [1:0] colorimetry;
        logic [1:0] picture_aspect;
        logic [3:0] format_aspect;
    } avir_colour_t;

    typedef struct packed {
        logic [5:0] spare;
        logic [1:0] uneven_resize;
    } avir_uneven_t;

    typedef struct packed {
        logic spare;
        logic [6:0] video_format_index;
    } avir_vfi_t;

    typedef struct packed {
        logic [7:0] version;
        avir_format_t format_status;
        avir_colour_t colour_aspect;
        avir_uneven_t uneven_scaling;
        avir_vfi_t video_format;
    } avir_frame_t;

    typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} avir_wr_st_t;
    typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} avir_rd_st_t;

    typedef struct packed {
        avir_wr_st_t wr_st;
        logic aw_got;
        logic w_got;
        logic [AXI_ADDR_W-1:0] wr_addr;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        avir_rd_st_t rd_st;
        logic arready;
        logic rvalid;
        logic [AXI_DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic have_frame;
        avir_frame_t frame;
        logic [FLAG_W-1:0] changed_packet_bits;
    } avir_state_t;

    localparam avir_state_t AVIR_RESET = '{
        wr_st: WR_IDLE,
        rd_st: RD_IDLE,
        bresp: RESP_OKAY,
        rresp: RESP_OKAY,
        default: '0
    };

endpackage

// *** hw/avir_readback.sv ***
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// - Colour space two bits: RGB, 422, 444
// - One bit flags active format present
// - Two-bit bar validity: none, horiz, vert, both
// - Scan field: none, overscanned, underscanned
// - Colorimetry code in byte's top bits
// - Active aspect code 1000 equals picture
// - Active aspect 1001/1010/1011 centred 4:3/16:9/14:9
// - Nonuniform scaling: none, horiz, vert, both
// - Seven-bit video format index from frame
// - Changed flags set; any flag read clears
module avir_readback
    import avir_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic frame_load,
    input wire avir_frame_t frame_in,
    input wire logic [FLAG_W-1:0] packet_change,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ************************************************************
    // State
    // ************************************************************
    avir_state_t s;
    avir_state_t next_s;

    logic aw_fire;
    logic w_fire;
    logic b_fire;
    logic ar_fire;
    logic r_fire;
    logic flag_read;
    logic avi_changed;
    avir_frame_t clean_frame;
    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] next_flags;

    assign aw_fire = s_axi_awvalid & s.awready;
    assign w_fire = s_axi_wvalid & s.wready;
    assign b_fire = s.bvalid & s_axi_bready;
    assign ar_fire = s_axi_arvalid & s.arready;
    assign r_fire = s.rvalid & s_axi_rready;

    // ************************************************************
    // Register table
    // ************************************************************
    // One entry per readable word; the two flag mirrors are the
    // last entries so the clear logic finds them by position
    localparam int N_REGS = 7;
    localparam int N_FIELDS = 5;
    localparam logic [WORD_IDX_W-1:0] REG_IDX [N_REGS] = '{
        IDX_VERSION,
        IDX_FORMAT,
        IDX_COLOUR,
        IDX_UNEVEN,
        IDX_VFI,
        IDX_FLAGS_A,
        IDX_FLAGS_B
    };

    logic [WORD_IDX_W-1:0] rd_idx;
    logic [WORD_IDX_W-1:0] wr_idx;
    logic [AXI_ADDR_W-1:0] wr_addr_now;
    logic [7:0] entry_byte [N_REGS];
    logic [N_REGS-1:0] rd_hit;
    logic [N_REGS-1:0] wr_hit;
    logic rd_mapped;
    logic wr_mapped;
    logic rd_is_flag;
    logic [7:0] rd_byte;
    logic [AXI_DATA_W-1:0] rd_word;

    // Byte lane bits below the word index are ignored
    function automatic logic [WORD_IDX_W-1:0] word_idx(
        input logic [AXI_ADDR_W-1:0] addr
    );
        word_idx = addr[AXI_ADDR_W-1:2];
    endfunction

    // Narrow registers sit in the low byte, upper bits read zero
    function automatic logic [AXI_DATA_W-1:0] widen(input logic [7:0] b);
        widen = {{(AXI_DATA_W - 8){1'b0}}, b};
    endfunction

    assign rd_idx = word_idx(s_axi_araddr);
    // Address of the write in flight, whichever beat came first
    assign wr_addr_now = aw_fire ? s_axi_awaddr : s.wr_addr;
    assign wr_idx = word_idx(wr_addr_now);

    assign entry_byte[0] = s.frame.version;
    assign entry_byte[1] = s.frame.format_status;
    assign entry_byte[2] = s.frame.colour_aspect;
    assign entry_byte[3] = s.frame.uneven_scaling;
    assign entry_byte[4] = s.frame.video_format;
    assign entry_byte[5] = {1'b0, s.changed_packet_bits};
    assign entry_byte[6] = {1'b0, s.changed_packet_bits};

    genvar gr;
    generate
        for (gr = 0; gr < N_REGS; gr++) begin : g_reg
            assign rd_hit[gr] = (rd_idx == REG_IDX[gr]);
            assign wr_hit[gr] = (wr_idx == REG_IDX[gr]);
        end
    endgenerate

    assign rd_mapped = |rd_hit;
    assign wr_mapped = |wr_hit;
    assign rd_is_flag = |rd_hit[N_REGS-1:N_FIELDS];

    // Hits are one-hot, so an AND-OR select needs no priority chain
    always_comb begin
        rd_byte = '0;
        for (int j = 0; j < N_REGS; j++) begin
            rd_byte = rd_byte | (entry_byte[j] & {8{rd_hit[j]}});
        end
    end

    assign rd_word = widen(rd_byte);

    // ************************************************************
    // Frame capture
    // ************************************************************
    // Spare bits are forced low so stray upstream bits can neither
    // show in a readback nor fake a content change
    always_comb begin
        clean_frame = frame_in;
        clean_frame.format_status.spare = 1'b0;
        clean_frame.uneven_scaling.spare = '0;
        clean_frame.video_format.spare = 1'b0;
    end

    // First frame after reset always counts as new content
    assign avi_changed = frame_load && (!s.have_frame || clean_frame != s.frame);

    // ************************************************************
    // Changed-packet flags
    // ************************************************************
    // Any read of either flag mirror clears all bits at the address
    // handshake; an event landing in that same cycle still sets
    assign flag_read = ar_fire && rd_is_flag;

    always_comb begin
        flag_set = packet_change;
        flag_set[FLAG_AVI] = packet_change[FLAG_AVI] | avi_changed;
    end

    genvar gi;
    generate
        for (gi = 0; gi < FLAG_W; gi++) begin : g_flag
            assign next_flags[gi] = flag_set[gi] |
                (s.changed_packet_bits[gi] & ~flag_read);
        end
    endgenerate

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s = s;

        // Captured fields change only through the frame port
        if (frame_load) begin
            next_s.frame = clean_frame;
            next_s.have_frame = 1'b1;
        end
        next_s.changed_packet_bits = next_flags;

        // Write channel: address and data taken in either order
        case (s.wr_st)
            WR_IDLE: begin
                if (aw_fire) begin
                    next_s.aw_got = 1'b1;
                    next_s.wr_addr = s_axi_awaddr;
                end
                if (w_fire) begin
                    next_s.w_got = 1'b1;
                end
                if (next_s.aw_got && next_s.w_got) begin
                    // Data is dropped; mapped registers answer OKAY
                    next_s.bvalid = 1'b1;
                    next_s.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
                    next_s.wr_st = WR_RESP;
                end
            end
            WR_RESP: begin
                if (b_fire) begin
                    next_s.bvalid = 1'b0;
                    next_s.bresp = RESP_OKAY;
                    next_s.aw_got = 1'b0;
                    next_s.w_got = 1'b0;
                    next_s.wr_st = WR_IDLE;
                end
            end
            default: begin
                next_s.wr_st = WR_IDLE;
                next_s.bvalid = 1'b0;
                next_s.aw_got = 1'b0;
                next_s.w_got = 1'b0;
            end
        endcase

        // Readies registered, so they drop the edge a beat is taken
        next_s.awready = (next_s.wr_st == WR_IDLE) && !next_s.aw_got;
        next_s.wready = (next_s.wr_st == WR_IDLE) && !next_s.w_got;

        // Read channel: data sampled at the address handshake
        case (s.rd_st)
            RD_IDLE: begin
                if (ar_fire) begin
                    next_s.rdata = rd_word;
                    next_s.rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
                    next_s.rvalid = 1'b1;
                    next_s.rd_st = RD_RESP;
                end
            end
            RD_RESP: begin
                if (r_fire) begin
                    next_s.rvalid = 1'b0;
                    next_s.rdata = '0;
                    next_s.rresp = RESP_OKAY;
                    next_s.rd_st = RD_IDLE;
                end
            end
            default: begin
                next_s.rd_st = RD_IDLE;
                next_s.rvalid = 1'b0;
            end
        endcase

        next_s.arready = (next_s.rd_st == RD_IDLE);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= AVIR_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;

endmodule

// *** verification/avir_readback_assertions.sv ***
`timescale 1ns/1ps
module avir_readback_assertions
    import avir_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic frame_load,
    input wire avir_frame_t frame_in,
    input wire logic [FLAG_W-1:0] packet_change,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****
    // Helper state
    // ****
    logic [39:0] fr;
    logic clean;
    logic [7:0] exp_b;
    wire logic [9:0] ri = s_axi_araddr[11:2];
    wire logic is_flag = (ri == IDX_FLAGS_A) || (ri == IDX_FLAGS_B);

    function automatic logic mapped(input logic [9:0] x);
        return (x >= IDX_VERSION && x <= IDX_VFI) || x == IDX_FLAGS_A || x == IDX_FLAGS_B;
    endfunction

    always_comb begin
        exp_b = 8'h00;
        if (ri >= IDX_VERSION && ri <= IDX_VFI) begin
            exp_b = fr[8 * (IDX_VFI - ri) +: 8];
        end
    end

    // Conservative: any frame load may set a flag, so it spoils the clean state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fr <= '0;
            clean <= 1'b1;
        end else begin
            if (frame_load) begin
                fr <= frame_in & 40'hff7fff037f;
            end
            if (frame_load || packet_change != '0) begin
                clean <= 1'b0;
            end else if (s_axi_arvalid && s_axi_arready && is_flag) begin
                clean <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence ar_take;
        s_axi_arvalid && s_axi_arready && !frame_load;
    endsequence
    sequence w_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_rd(logic [9:0] x);
        ar_take ##0 (ri == x) |=> s_axi_rdata == {24'h0, $past(exp_b)} && s_axi_rresp == RESP_OKAY;
    endproperty

    AST_FORMAT_READ: assert property (p_rd(IDX_FORMAT))
        else $error("format byte readback wrong");
    AST_COLOUR_READ: assert property (p_rd(IDX_COLOUR))
        else $error("colour byte readback wrong");
    AST_UNEVEN_READ: assert property (p_rd(IDX_UNEVEN))
        else $error("scaling byte readback wrong");
    AST_VFI_READ: assert property (p_rd(IDX_VFI))
        else $error("format index readback wrong");
    AST_FLAG_CLEAR: assert property (ar_take ##0 (is_flag && clean) |=> s_axi_rdata == '0)
        else $error("flags not cleared by read");
    AST_WRITE_IGNORED: assert property (w_take |=> s_axi_bvalid &&
        s_axi_bresp == (mapped($past(s_axi_awaddr[11:2])) ? RESP_OKAY : RESP_SLVERR))
        else $error("write response wrong");
    AST_UNMAPPED_READ: assert property (ar_take ##0 !mapped(ri) |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0) else $error("unmapped read wrong");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata)) else $error("read answer not held");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
        $stable(s_axi_bresp)) else $error("write answer not held");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
        else $error("read channel not reopened");
endmodule

bind avir_readback avir_readback_assertions u_chk (.*);

// *** verification/avir_source.sv ***
`timescale 1ns/1ps
module avir_source
    import avir_pkg::*;
(
    input wire logic aclk,
    output avir_frame_t frame_in,
    output logic frame_load,
    output logic [FLAG_W-1:0] packet_change
);
    initial begin
        frame_in = '0;
        frame_load = 1'b0;
        packet_change = '0;
    end

    // Released frame bus shows the inverse so stale data never looks valid
    task automatic send(input logic ld, input avir_frame_t f, input logic [FLAG_W-1:0] c);
        @(posedge aclk);
        frame_load <= ld;
        frame_in <= f;
        packet_change <= c;
        @(posedge aclk);
        frame_load <= 1'b0;
        frame_in <= ~f;
        packet_change <= '0;
    endtask
endmodule

// *** verification/avir_readback_tb_top.sv ***
`timescale 1ns/1ps
module avir_readback_tb_top;
    import avir_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, frame_load;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    avir_frame_t frame_in;
    logic [6:0] packet_change, c;
    logic [39:0] fr = '0, f;
    int n_mismatch = 0, cmp_count = 0, seed = 46777, flg = 0, i, k;

    always #4 aclk = ~aclk;

    avir_source src (.aclk(aclk), .frame_in(frame_in), .frame_load(frame_load),
        .packet_change(packet_change));
    avir_readback dut (.aclk(aclk), .aresetn(aresetn), .frame_load(frame_load),
        .frame_in(frame_in), .packet_change(packet_change), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // Handshakes are judged at the falling edge, where outputs have settled,
    // so the bench never races the edge that launches them
    task wr(input logic [9:0] x, input logic [31:0] v, output logic [1:0] rs);
        logic aw_s, w_s, b_s;
        @(posedge aclk);
        awaddr <= {x, 2'b00};
        wdata <= v;
        wstrb <= 4'($random(seed));
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_s = awvalid && awready;
            w_s = wvalid && wready;
            b_s = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (aw_s) awvalid <= 1'b0;
            if (w_s) wvalid <= 1'b0;
        end while (!b_s);
        bready <= 1'b0;
    endtask

    task rd(input logic [9:0] x, output logic [31:0] v, output logic [1:0] rs);
        logic ar_s, r_s;
        @(posedge aclk);
        araddr <= {x, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_s = arvalid && arready;
            r_s = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ar_s) arvalid <= 1'b0;
        end while (!r_s);
        rready <= 1'b0;
    endtask

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 0; k < 5; k++) begin
            rd(IDX_VERSION + 10'(k), d, r);
            chk("reset field", 32'h0, d);
        end
        for (i = 0; i < 12; i++) begin
            f = {8'($random(seed)), 1'($random(seed)), 2'(i % 3), 1'(i), 2'(i % 4), 2'(i % 3),
                2'(i % 3), 2'($random(seed)), 4'(8 + i % 4), 6'($random(seed)), 2'(i % 4),
                8'($random(seed))};
            if (i == 5) f = fr;
            c = 7'($random(seed));
            if (i == 0 || (f & 40'hff7fff037f) != fr) flg = flg | 1;
            flg = flg | int'(c);
            fr = f & 40'hff7fff037f;
            src.send(1'b1, f, c);
            wr(IDX_VERSION + 10'(i % 5), $random(seed), r);
            chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
            for (k = 0; k < 5; k++) begin
                rd(IDX_VERSION + 10'(k), d, r);
                chk("field", {24'h0, fr[39 - 8 * k -: 8]}, d);
            end
            rd((i % 2) ? IDX_FLAGS_B : IDX_FLAGS_A, d, r);
            chk("flags", 32'(flg), d);
            flg = 0;
        end
        src.send(1'b0, '0, 7'h40);
        rd(IDX_FLAGS_A, d, r);
        chk("flags pulse", 32'h40, d);
        // Event and clearing read at one edge: the event must survive
        fork
            rd(IDX_FLAGS_B, d, r);
            src.send(1'b0, '0, 7'h02);
        join
        chk("flags at clear", 32'h0, d);
        rd(IDX_FLAGS_A, d, r);
        chk("flags set wins", 32'h02, d);
        rd(IDX_FLAGS_B, d, r);
        chk("flags cleared", 32'h0, d);
        wr(10'h085, $random(seed), r);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
        rd(10'h3ff, d, r);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped rdata", 32'h0, d);
        // Mid-run reset wipes the captured frame and the flags
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        fr = '0;
        for (k = 0; k < 5; k++) begin
            rd(IDX_VERSION + 10'(k), d, r);
            chk("field after reset", 32'h0, d);
        end
        rd(IDX_FLAGS_B, d, r);
        chk("flags after reset", 32'h0, d);
        src.send(1'b1, '0, 7'h00);
        rd(IDX_FLAGS_A, d, r);
        chk("first frame flag", 32'h1, d);
        report_and_stop;
    end
endmodule
